// ==== rtl/floppy_motor_regs.svh ====
// Constants for the floppy motor and step control block:
// register offsets, field positions, reset values, timing counts.
// Assumes a 125 MHz pclk and a 32-bit APB register bus.
`ifndef FLOPPY_MOTOR_REGS_SVH
`define FLOPPY_MOTOR_REGS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04

// Control fields and reset value
`define CTRL_SPIN_EN 0
`define CTRL_STEP_EN 1
`define CTRL_RESET 2'h3

// Phase register value forced by power-on reset (phase 2)
`define PHASE_POR 4'h2

// Clock period and spindle timing
`define CLK_NS 8
`define SPIN_RPM 300
`define TACH_PER_REV 4
`define REV_NS (1000000000 / (`SPIN_RPM / 60))
`define TACH_TARGET_CYC (`REV_NS / (`CLK_NS * `TACH_PER_REV))

// Strobe clock period, half period in pclk cycles
`define STROBE_NS 1000
`define STROBE_HALF_CYC (`STROBE_NS / (2 * `CLK_NS))

// Stepping counts in strobe cycles
`define SETTLE_CONV 16'd3000
`define SETTLE_BURST 16'd1000
`define BURST_GAP 16'd5000
`define HOLD_DELAY 16'd20000

// Synchroniser bit positions
`define SY_STEP 0
`define SY_DIR 1
`define SY_TACH 2
`define SY_SEL 3
`define SY_MOT 4
`define SY_WRT 5
`define SY_WPT 6
`define SY_WDA 7

`endif

// ==== rtl/floppy_motor_pkg.sv ====
// Types for the floppy motor and step control block.
// Assumes the constants header is on the include path.
`include "floppy_motor_regs.svh"

package floppy_motor_pkg;

  // Positioner sequencer states
  typedef enum logic [2:0] {
    st_wait = 3'b001,
    st_busy = 3'b010,
    st_hold = 3'b100
  } ctl_state_type;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic [7:0] prev;
    logic strobe;
    logic [5:0] div;
    logic step_latch;
    logic dir_latch;
    logic [3:0] phase;
    logic busy;
    logic hold;
    ctl_state_type state;
    logic [15:0] scnt;
    logic [15:0] gap;
    logic burst;
    logic [24:0] tcnt;
    logic req;
    logic drive;
    logic mdrv;
    logic wen;
    logic wcur;
    logic [1:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } regs_type;

endpackage

// ==== rtl/floppy_motor_step_control.sv ====
// Motor and positioner glue logic of a flexible disk drive:
// step/direction latches, phase register, hold, spindle PWM drive,
// write enable and write current flip-flop, with an APB slave.
// Assumes host pins are asynchronous and pass two flip-flops first.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "floppy_motor_regs.svh"

module floppy_motor_step_control #(
  parameter logic [24:0] TACH_TARGET = 25'(`TACH_TARGET_CYC),
  parameter logic [15:0] HOLD_DELAY = `HOLD_DELAY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_step_n,
  input wire logic host_direction_n,
  input wire logic drive_select_n,
  input wire logic motor_on_n,
  input wire logic write_mode,
  input wire logic write_protect,
  input wire logic write_data_pulse,
  input wire logic spindle_tach_pulse_n,
  output logic controller_strobe_clock,
  output logic [3:0] phase_out,
  output logic hold_out,
  output logic step_busy_reg,
  output logic step_latched,
  output logic direction_latched,
  output logic spindle_drive,
  output logic write_enable,
  output logic write_busy,
  output logic write_current
);
  import floppy_motor_pkg::*;

  regs_type q;
  regs_type d;
  logic [7:0] pins;
  logic tick;
  logic tach_ev;
  logic step_ev;
  logic wda_ev;
  logic acc;
  logic [31:0] status;

  //////////////////////////////////////////////////////////////////
  // Pin gathering and edge events from the second sync stage
  assign pins = {write_data_pulse, write_protect, write_mode, motor_on_n,
                 drive_select_n, spindle_tach_pulse_n, host_direction_n,
                 host_step_n};
  // Inverted strobe rises when the strobe falls
  assign tick = (q.div == 6'h00) && q.strobe;
  assign tach_ev = q.prev[`SY_TACH] && !q.sy2[`SY_TACH];
  assign step_ev = !q.prev[`SY_STEP] && q.sy2[`SY_STEP];
  assign wda_ev = !q.prev[`SY_WDA] && q.sy2[`SY_WDA];
  assign acc = psel && penable && q.pready;

  // Status word seen by software
  assign status = {17'h0, q.state, q.burst, q.req, q.drive, q.wen,
                   q.hold, q.busy, q.dir_latch, q.step_latch, q.phase};

  //////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    d.sy1 = pins;
    d.sy2 = q.sy1;
    d.prev = q.sy2;
    d.pready = 1'b0;

    // Strobe clock divider
    if (q.div == 6'h00)
    begin
      d.div = 6'(`STROBE_HALF_CYC - 1);
      d.strobe = !q.strobe;
    end
    else
    begin
      d.div = q.div - 6'h01;
    end

    // Tach period measure, slow means request drive
    if (tach_ev)
    begin
      d.req = q.tcnt > TACH_TARGET;
      d.tcnt = 25'h0;
    end
    else
    begin
      if (q.tcnt != 25'h1ffffff)
      begin
        d.tcnt = q.tcnt + 25'h1;
      end
      if (q.tcnt > TACH_TARGET)
      begin
        d.req = 1'b1;
      end
    end

    // Spindle drive flop, tach clear dominates
    if (tach_ev)
    begin
      d.drive = 1'b0;
    end
    else if (tick)
    begin
      d.drive = q.req && q.ctrl[`CTRL_SPIN_EN];
    end
    // Power stage gated by motor-on
    d.mdrv = d.drive && !q.sy2[`SY_MOT];

    // Controller clears the latch when it takes a step
    if (tick && q.step_latch && q.state != st_busy && q.ctrl[`CTRL_STEP_EN])
    begin
      d.step_latch = 1'b0;
      d.burst = q.gap < `BURST_GAP;
      d.gap = 16'h0;
      d.busy = 1'b1;
      d.hold = 1'b0;
      d.state = st_busy;
      d.scnt = (q.gap < `BURST_GAP) ? `SETTLE_BURST : `SETTLE_CONV;
      // Advance the phase by the latched direction
      if (q.dir_latch)
      begin
        d.phase = {q.phase[2:0], q.phase[3]};
      end
      else
      begin
        d.phase = {q.phase[0], q.phase[3:1]};
      end
    end
    else if (tick)
    begin
      if (q.gap != 16'hffff)
      begin
        d.gap = q.gap + 16'h1;
      end
      case (q.state)
        st_busy:
        begin
          if (q.scnt == 16'h0)
          begin
            d.busy = 1'b0;
            d.scnt = HOLD_DELAY;
            d.state = st_wait;
          end
          else
          begin
            d.scnt = q.scnt - 16'h1;
          end
        end
        st_wait:
        begin
          if (q.scnt == 16'h0)
          begin
            d.hold = 1'b1;
            d.state = st_hold;
          end
          else
          begin
            d.scnt = q.scnt - 16'h1;
          end
        end
        st_hold:
        begin
          d.hold = 1'b1;
        end
        default:
        begin
          d.state = st_hold;
        end
      endcase
    end

    // Selected host step sets latch, deselected one clears it; a new step wins over the clear
    if (step_ev)
    begin
      d.step_latch = !q.sy2[`SY_SEL];
    end
    // Direction caught on rising latch only
    if (d.step_latch && !q.step_latch)
    begin
      d.dir_latch = !q.sy2[`SY_DIR];
    end

    // Write gating
    d.wen = q.sy2[`SY_WRT] && !q.sy2[`SY_WPT] && !q.sy2[`SY_SEL] && !q.busy;
    // Write current flips once per data pulse
    if (!q.wen)
    begin
      d.wcur = 1'b0;
    end
    else if (wda_ev)
    begin
      d.wcur = !q.wcur;
    end

    // APB: answer in setup, access completes on next edge
    if (psel && !penable)
    begin
      d.pready = 1'b1;
      d.pslverr = !(paddr == `OFS_CTRL || paddr == `OFS_STATUS);
      d.prdata = 32'h0;
      if (!pwrite && paddr == `OFS_CTRL)
      begin
        d.prdata = {30'h0, q.ctrl};
      end
      else if (!pwrite && paddr == `OFS_STATUS)
      begin
        d.prdata = status;
      end
    end
    if (acc && pwrite && paddr == `OFS_CTRL)
    begin
      d.ctrl = pwdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////
  // State register, phase 2 during power-on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.sy1 <= 8'hff;
      q.sy2 <= 8'hff;
      q.prev <= 8'hff;
      q.phase <= `PHASE_POR;
      q.state <= st_wait;
      q.scnt <= HOLD_DELAY;
      q.ctrl <= `CTRL_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign controller_strobe_clock = q.strobe;
  assign phase_out = q.phase;
  assign hold_out = q.hold;
  assign step_busy_reg = q.busy;
  assign step_latched = q.step_latch;
  assign direction_latched = q.dir_latch;
  assign spindle_drive = q.mdrv;
  assign write_enable = q.wen;
  assign write_busy = q.wen;
  assign write_current = q.wcur;

  //////////////////////////////////////////////////////////////////
  // Checks
  a_write_busy_block: assert property (@(posedge pclk) disable iff (!presetn)
    q.busy |=> !q.wen)
    else $error("write enabled while stepping");

  a_write_enable_cond: assert property (@(posedge pclk) disable iff (!presetn)
    q.wen |-> $past(q.sy2[`SY_WRT] && !q.sy2[`SY_WPT] && !q.sy2[`SY_SEL]))
    else $error("write enabled without conditions");

  a_tach_clears: assert property (@(posedge pclk) disable iff (!presetn)
    tach_ev |=> !q.drive && !q.mdrv)
    else $error("tach pulse did not end drive");

  a_drive_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && q.req && q.ctrl[0] && !tach_ev) |=> q.drive)
    else $error("drive not set on strobe");

  a_drive_drops: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !q.req && !tach_ev) |=> !q.drive)
    else $error("drive not cleared on strobe");

  a_motor_gate: assert property (@(posedge pclk) disable iff (!presetn)
    q.mdrv |-> $past(!q.sy2[`SY_MOT]))
    else $error("spindle driven with motor off");

  a_phase_steady: assert property (@(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(q.phase) && $onehot(q.phase))
    else $error("phase changed off strobe edge");

  a_dir_capture: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.step_latch) |-> q.dir_latch == !$past(q.sy2[`SY_DIR]))
    else $error("direction not latched");

  a_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
    q.hold |-> !q.busy)
    else $error("hold while stepping");

  a_flux_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (q.wen && wda_ev) |=> q.wcur != $past(q.wcur))
    else $error("write current not reversed");

  c_step_done: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(q.busy));
  c_hold_entry: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(q.hold));
  c_spindle_pulse: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(q.mdrv));
  c_flux: cover property (@(posedge pclk) disable iff (!presetn)
    q.wen && wda_ev);

endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host disk controller model: step, direction, select, write pins.
// Assumes the bench calls its tasks from the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic pclk,
  output logic host_step_n,
  output logic host_direction_n,
  output logic drive_select_n,
  output logic write_mode,
  output logic write_data_pulse
);
  // Idle host: no step, deselected, reading
  initial
  begin
    host_step_n = 1'b1;
    host_direction_n = 1'b1;
    drive_select_n = 1'b1;
    write_mode = 1'b0;
    write_data_pulse = 1'b0;
  end

  // Select and write mode lines
  task automatic set_lines(input logic sel_n, input logic wmode);
    begin
      @(posedge pclk);
      drive_select_n <= sel_n;
      write_mode <= wmode;
    end
  endtask

  // Low step pulse; direction set up first and held through the rising end
  task automatic step_pulse(input logic dir_n);
    begin
      @(posedge pclk);
      host_direction_n <= dir_n;
      repeat (2) @(posedge pclk);
      host_step_n <= 1'b0;
      repeat (4) @(posedge pclk);
      host_step_n <= 1'b1;
    end
  endtask

  // One already encoded pulse per wanted flux reversal
  task automatic write_pulse;
    begin
      @(posedge pclk);
      write_data_pulse <= 1'b1;
      repeat (4) @(posedge pclk);
      write_data_pulse <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Testbench: APB master, host model, tach pin; self-checking.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic host_step_n, host_direction_n, drive_select_n, motor_on_n, write_mode;
  logic write_protect, write_data_pulse, spindle_tach_pulse_n;
  logic controller_strobe_clock, hold_out, step_busy_reg, step_latched;
  logic direction_latched, spindle_drive, write_enable, write_busy, write_current;
  logic [3:0] phase_out;
  // Rows: write mode, protect, select_n, expected write enable
  logic [3:0] rows [5] = '{4'b1001, 4'b0000, 4'b1100, 4'b1010, 4'b0110};
  int miscompares = 0;
  int checks = 0;
  int n;

  floppy_motor_step_control #(.TACH_TARGET(25'd200), .HOLD_DELAY(16'd5)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_step_n(host_step_n), .host_direction_n(host_direction_n),
    .drive_select_n(drive_select_n), .motor_on_n(motor_on_n), .write_mode(write_mode),
    .write_protect(write_protect), .write_data_pulse(write_data_pulse),
    .spindle_tach_pulse_n(spindle_tach_pulse_n), .controller_strobe_clock(controller_strobe_clock),
    .phase_out(phase_out), .hold_out(hold_out), .step_busy_reg(step_busy_reg),
    .step_latched(step_latched), .direction_latched(direction_latched),
    .spindle_drive(spindle_drive), .write_enable(write_enable), .write_busy(write_busy),
    .write_current(write_current));

  host_model host (.pclk(pclk), .host_step_n(host_step_n), .host_direction_n(host_direction_n),
    .drive_select_n(drive_select_n), .write_mode(write_mode), .write_data_pulse(write_data_pulse));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic finish_test;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
      begin
        $display("SIMULATION PASSED");
      end
      else
      begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checks++;
      if (got !== exp)
      begin
        $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        miscompares++;
      end
    end
  endtask

  // One APB transfer; waits for pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Tach pulse; lines up with a strobe tick first when asked
  task automatic tach(input logic align);
    begin
      if (align)
      begin
        @(negedge controller_strobe_clock);
      end
      @(posedge pclk);
      spindle_tach_pulse_n <= 1'b0;
      repeat (4) @(posedge pclk);
      spindle_tach_pulse_n <= 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #(20000 * 8);
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    write_protect = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    motor_on_n = 1'b1;
    spindle_tach_pulse_n = 1'b1;
    repeat (10) @(posedge pclk);
    check(phase_out, 4'h2, "reset phase");
    check({hold_out, step_busy_reg, spindle_drive, write_enable}, 4'h0, "reset outs");
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    $display("test reset done");
    // Write enable gating table
    foreach (rows[i])
    begin
      host.set_lines(rows[i][1], rows[i][3]);
      write_protect <= rows[i][2];
      repeat (8) @(posedge pclk);
      check({write_enable, write_busy}, {2{rows[i][0]}}, "write enable");
    end
    $display("test rows done");
    check(hold_out, 1'b0, "no hold yet");
    host.set_lines(1'b0, 1'b1);
    write_protect <= 1'b0;
    repeat (8) @(posedge pclk);
    host.write_pulse();
    repeat (8) @(posedge pclk);
    check(write_current, 1'b1, "flux one");
    host.write_pulse();
    repeat (8) @(posedge pclk);
    check(write_current, 1'b0, "flux two");
    $display("test write done");
    // Registers
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h3, "ctrl reset");
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0, "ctrl rw");
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    check({err, rd}, {1'b1, 32'h0}, "unmapped");
    $display("test regs done");
    // Spindle
    repeat (300) @(posedge pclk);
    check(spindle_drive, 1'b0, "motor off");
    motor_on_n <= 1'b0;
    n = 0;
    while (spindle_drive !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    check(spindle_drive, 1'b1, "slow drive");
    tach(1'b1);
    repeat (8) @(posedge pclk);
    check(spindle_drive, 1'b0, "tach clear");
    for (int k = 0; k < 8; k++)
    begin
      repeat (55) @(posedge pclk);
      if (k > 3)
      begin
        check(spindle_drive, 1'b0, "fast off");
      end
      tach(1'b0);
    end
    $display("test spindle done");
    check(hold_out, 1'b1, "hold idle");
    // Stepping
    host.set_lines(1'b1, 1'b1);
    host.step_pulse(1'b0);
    repeat (8) @(posedge pclk);
    check(step_latched, 1'b0, "deselected step");
    host.set_lines(1'b0, 1'b1);
    @(negedge controller_strobe_clock);
    host.step_pulse(1'b0);
    repeat (6) @(posedge pclk);
    check({step_latched, direction_latched}, 2'b11, "latch");
    host.step_pulse(1'b1);
    check(direction_latched, 1'b1, "dir held");
    repeat (140) @(posedge pclk);
    check(phase_out, 4'h4, "phase step");
    check({step_busy_reg, hold_out, step_latched}, 3'b100, "busy");
    check(write_enable, 1'b0, "write withheld");
    host.step_pulse(1'b1);
    repeat (140) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[6:0], 7'b1010100, "status busy");
    check(rd[14:11], 4'h5, "burst mode");
    $display("test step done");
    // Reset in mid-run brings phase 2 back and drops busy
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({phase_out, step_busy_reg}, 5'b00100, "reset again");
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({step_busy_reg, hold_out}, 2'b00, "after reset");
    $display("test reset again done");
    finish_test();
  end
endmodule
`default_nettype wire
